// ### hw/sac_cfg.svh
// Purpose: addresses, field positions, reset values and counts of the converter control
// Assumes: 8-bit special-function register bus with a page select
// Notes:   definitions only
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SAC_PAGE_CONV      4'h0
`define SAC_ADDR_CONTROL  8'he8
`define SAC_ADDR_CONFIG   8'hbc

// ----------------------------------------------------------------
// converter_control fields
// ----------------------------------------------------------------
`define SAC_CTL_ENABLE    7
`define SAC_CTL_BURST     6
`define SAC_CTL_DONE      5
`define SAC_CTL_BUSY      4
`define SAC_CTL_WINDOW    3
`define SAC_CTL_SRC_HI    2
`define SAC_CTL_SRC_LO    0
`define SAC_CONTROL_RESET 8'h00

// ----------------------------------------------------------------
// converter_configuration fields
// ----------------------------------------------------------------
`define SAC_CFG_DIV_HI    7
`define SAC_CFG_DIV_LO    3
`define SAC_CFG_EIGHT     2
`define SAC_CFG_TRACK     1
`define SAC_CFG_GAIN      0
`define SAC_CONFIG_RESET  8'hf8

// ----------------------------------------------------------------
// start sources and timing in sar clocks
// ----------------------------------------------------------------
`define SAC_SRC_SOFTWARE  3'h0
`define SAC_SRC_TIMER0    3'h1
`define SAC_SRC_TIMER2    3'h2
`define SAC_SRC_TIMER3    3'h3
`define SAC_TRACK_CLKS    4'h3
`define SAC_BITS_10       4'ha
`define SAC_BITS_8        4'h8

`endif

// ### hw/sac_pkg.sv
// Purpose: types of the converter control block
// Assumes: constants come from sac_cfg.svh
// Notes:   all state of the block lives in sac_state_type
package sac_pkg;

	typedef enum logic [1:0] {
		SAC_IDLE    = 2'b00,
		SAC_TRACK   = 2'b01,
		SAC_CONVERT = 2'b10
	} sac_phase_type;

	typedef struct packed {
		logic          ctrl_enable;
		logic          burst;
		logic          done_flag;
		logic          window_flag;
		logic [2:0]    start_source;
		logic [4:0]    divider;
		logic          eight_bit;
		logic          track_delay;
		logic          gain_one;
		sac_phase_type phase;
		logic [4:0]    div_count;
		logic [3:0]    step_count;
		logic [6:0]    conv_count;
		logic          from_pin;
		logic          pin_meta;
		logic          pin_sync;
		logic          pin_last;
		logic          osc_meta;
		logic          osc_sync;
		logic          osc_last;
		logic [9:0]    result;
		logic [7:0]    rdata;
		logic          power_on;
		logic          tracking;
		logic          converting;
		logic          sar_tick;
	} sac_state_type;

endpackage

// ### hw/sac_control.sv
// Purpose: control and configuration of a 10-bit successive-approximation converter
// Assumes: sfr bus and timer pulses on sys_clk; start pin and oscillator asynchronous
// Notes:   read data is registered, one cycle after sfr_rd
//
// What this block does
// - enable bit zero holds converter shut down unless bursting
// - burst bit selects burst or single conversions
// - done flag set after conversion or burst
// - done flag raises request, software clears only
// - software start by writing busy bit
// - window flag set when result inside window
// - source codes select timer 0, 2, 3
// - source 1xx starts on pin rising edge
// - sar clock is source over divider+1
// - divider source: system clock or oscillator
// - eight-bit bit selects 8-bit conversions
// - normal tracking converts right after start
// - delayed tracking waits 3 sar clocks
// - gain bit selects half or unity gain
// - control register at e8, resets zero
// - configuration register at bc, page zero
// - 8-bit mode zeroes two lsbs, shorter
// - non-pin burst start launches repeat-count conversions
// - burst with enable low powers down after
`include "sac_cfg.svh"
`timescale 1ns/1ps

module sac_control
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       arst_n,
	// special-function register bus
	input  wire logic [3:0] sfr_page,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_rd,
	input  wire logic       sfr_bit_wr,
	input  wire logic [2:0] sfr_bit_sel,
	input  wire logic       sfr_bit_val,
	output logic      [7:0] sfr_rdata,
	// start sources
	input  wire logic       timer0_overflow,
	input  wire logic       timer2_overflow,
	input  wire logic       timer3_overflow,
	input  wire logic       external_convert_start_pin,
	// burst clock and repeat code from the accumulator setup
	input  wire logic       lp_osc_clk,
	input  wire logic [2:0] repeat_code,
	// analog core and window thresholds
	input  wire logic [9:0] sample_bits,
	input  wire logic [9:0] window_greater_than,
	input  wire logic [9:0] window_less_than,
	output logic            converter_power_on,
	output logic            converter_tracking,
	output logic            converter_converting,
	output logic            sar_conversion_clock,
	output logic            eight_bit_mode_enable,
	output logic            input_gain_select,
	// results and requests
	output logic      [7:0] result_high_byte,
	output logic      [7:0] result_low_byte,
	output logic            conversion_done_flag,
	output logic            window_match_flag
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	sac_state_type r;
	sac_state_type next_r;

	logic       page_ok;
	logic       wr_control;
	logic       wr_config;
	logic [7:0] control_now;
	logic [7:0] control_wdata;
	logic       sw_start;
	logic       pin_rise;
	logic       osc_rise;
	logic       start_event;
	logic       source_tick;
	logic [3:0] last_step;
	logic [6:0] repeat_total;
	logic [9:0] captured;
	logic       burst_done;
	logic       tick_now;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.sar_tick = 1'b0;

		// two-stage synchronisers; only the second stage is read
		next_r.pin_meta = external_convert_start_pin;
		next_r.pin_sync = r.pin_meta;
		next_r.pin_last = r.pin_sync;
		next_r.osc_meta = lp_osc_clk;
		next_r.osc_sync = r.osc_meta;
		next_r.osc_last = r.osc_sync;
		pin_rise = r.pin_sync & ~r.pin_last;
		osc_rise = r.osc_sync & ~r.osc_last;

		// register writes; byte and bit access share one path
		page_ok = (sfr_page == `SAC_PAGE_CONV);
		control_now = {r.ctrl_enable, r.burst, r.done_flag, 1'b0,
			r.window_flag, r.start_source};
		control_wdata = sfr_wdata;
		wr_control = 1'b0;
		wr_config = 1'b0;
		if (page_ok && sfr_wr && sfr_addr == `SAC_ADDR_CONTROL) begin
			wr_control = 1'b1;
		end
		if (page_ok && sfr_bit_wr) begin
			wr_control = 1'b1;
			control_wdata = control_now;
			control_wdata[sfr_bit_sel] = sfr_bit_val;
		end
		if (page_ok && sfr_wr && sfr_addr == `SAC_ADDR_CONFIG) begin
			wr_config = 1'b1;
		end
		// busy bit is a write-only start strobe
		sw_start = wr_control && control_wdata[`SAC_CTL_BUSY];
		if (wr_control) begin
			next_r.ctrl_enable  = control_wdata[`SAC_CTL_ENABLE];
			next_r.burst        = control_wdata[`SAC_CTL_BURST];
			next_r.done_flag    = control_wdata[`SAC_CTL_DONE];
			next_r.window_flag  = control_wdata[`SAC_CTL_WINDOW];
			next_r.start_source = control_wdata[`SAC_CTL_SRC_HI:`SAC_CTL_SRC_LO];
		end
		if (wr_config) begin
			next_r.divider     = sfr_wdata[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO];
			next_r.eight_bit   = sfr_wdata[`SAC_CFG_EIGHT];
			next_r.track_delay = sfr_wdata[`SAC_CFG_TRACK];
			next_r.gain_one    = sfr_wdata[`SAC_CFG_GAIN];
		end

		// read data, registered; busy reads back as the running state
		next_r.rdata = 8'h00;
		if (page_ok && sfr_rd && sfr_addr == `SAC_ADDR_CONTROL) begin
			next_r.rdata = control_now;
			next_r.rdata[`SAC_CTL_BUSY] = (r.phase != SAC_IDLE);
		end
		if (page_ok && sfr_rd && sfr_addr == `SAC_ADDR_CONFIG) begin
			next_r.rdata = {r.divider, r.eight_bit, r.track_delay, r.gain_one};
		end

		// start source selection; a write that sets busy also sets the source it starts from
		case (next_r.start_source)
			`SAC_SRC_SOFTWARE: start_event = sw_start;
			`SAC_SRC_TIMER0:   start_event = timer0_overflow;
			`SAC_SRC_TIMER2:   start_event = timer2_overflow;
			`SAC_SRC_TIMER3:   start_event = timer3_overflow;
			// any 1xx code uses the pin edge
			default:           start_event = pin_rise;
		endcase

		// one conversion per start unless bursting
		if (!r.burst) begin
			repeat_total = 7'h01;
		end else begin
			case (repeat_code)
				3'h1:    repeat_total = 7'h04;
				3'h2:    repeat_total = 7'h08;
				3'h3:    repeat_total = 7'h10;
				3'h4:    repeat_total = 7'h20;
				3'h5:    repeat_total = 7'h40;
				default: repeat_total = 7'h01;
			endcase
		end

		// divider source: every system clock, or each oscillator rising edge
		source_tick = r.burst ? osc_rise : 1'b1;
		// two fewer sar clocks in 8-bit mode
		last_step = (r.eight_bit ? `SAC_BITS_8 : `SAC_BITS_10) - 4'h1;
		// lsbs forced to zero in 8-bit mode
		captured = r.eight_bit ? {sample_bits[9:2], 2'b00} : sample_bits;
		burst_done = (r.conv_count + 7'h01) == repeat_total;

		// sar clock divider, runs only while a conversion is active
		// the tick is used in the cycle it is made, so no sar clock is lost at the start
		tick_now = 1'b0;
		if (r.phase == SAC_IDLE) begin
			next_r.div_count = 5'h00;
		end else if (source_tick) begin
			if (r.div_count == r.divider) begin
				next_r.div_count = 5'h00;
				tick_now = 1'b1;
			end else begin
				next_r.div_count = r.div_count + 5'h01;
			end
		end
		next_r.sar_tick = tick_now;

		case (r.phase)
			SAC_IDLE: begin
				// shut down ignores starts unless bursting
				if (start_event && (next_r.ctrl_enable || next_r.burst)) begin
					next_r.from_pin = next_r.start_source[2];
					next_r.step_count = 4'h0;
					next_r.phase = r.track_delay ? SAC_TRACK : SAC_CONVERT;
				end
			end
			SAC_TRACK: begin
				if (tick_now) begin
					if (r.step_count == `SAC_TRACK_CLKS - 4'h1) begin
						next_r.step_count = 4'h0;
						next_r.phase = SAC_CONVERT;
					end else begin
						next_r.step_count = r.step_count + 4'h1;
					end
				end
			end
			SAC_CONVERT: begin
				if (tick_now) begin
					if (r.step_count == last_step) begin
						next_r.step_count = 4'h0;
						next_r.result = captured;
						next_r.phase = SAC_IDLE;
						if (burst_done) begin
							next_r.conv_count = 7'h00;
						end else begin
							next_r.conv_count = r.conv_count + 7'h01;
							// non-pin bursts chain on their own
							if (r.burst && !r.from_pin) begin
								next_r.phase = r.track_delay ? SAC_TRACK : SAC_CONVERT;
							end
						end
					end else begin
						next_r.step_count = r.step_count + 4'h1;
					end
				end
			end
			default: begin
				next_r.phase = SAC_IDLE;
			end
		endcase
		// start events are only looked at in idle

		// clearing enable aborts a single conversion
		if (!next_r.ctrl_enable && !next_r.burst) begin
			next_r.phase = SAC_IDLE;
			next_r.conv_count = 7'h00;
		end

		// hardware set wins over a software clear in the same cycle
		if (r.phase == SAC_CONVERT && tick_now && r.step_count == last_step
			&& burst_done) begin
			next_r.done_flag = 1'b1;
			// window compare on the finished result only
			if (captured > window_greater_than && captured < window_less_than) begin
				next_r.window_flag = 1'b1;
			end
		end

		// power: enable keeps it up, a burst wakes it only while busy
		next_r.power_on = next_r.ctrl_enable
			| (next_r.burst & (next_r.phase != SAC_IDLE));
		// normal mode tracks continuously between conversions while enabled and not bursting
		next_r.tracking = (next_r.phase == SAC_TRACK)
			| (next_r.phase == SAC_IDLE & next_r.ctrl_enable
			& ~next_r.track_delay & ~next_r.burst);
		next_r.converting = (next_r.phase == SAC_CONVERT);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= '0;
			r.phase <= SAC_IDLE;
			// control resets to zero with the rest of the state
			{r.divider, r.eight_bit, r.track_delay, r.gain_one} <= `SAC_CONFIG_RESET;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign sfr_rdata             = r.rdata;
	assign converter_power_on    = r.power_on;
	assign converter_tracking    = r.tracking;
	assign converter_converting  = r.converting;
	assign sar_conversion_clock  = r.sar_tick;
	assign eight_bit_mode_enable = r.eight_bit;
	// gain select straight from the register
	assign input_gain_select     = r.gain_one;
	// left-justified so the low byte reads zero in 8-bit mode
	assign result_high_byte      = r.result[9:2];
	assign result_low_byte       = {r.result[1:0], 6'h00};
	assign conversion_done_flag  = r.done_flag;
	assign window_match_flag     = r.window_flag;

endmodule

// ### testbench/sac_control_asserts.sv
// Purpose: port checks of the converter control
// Assumes: bound to sac_control, one clock domain
// Notes:   shadows of written fields stand in for hidden state
`timescale 1ns/1ps
module sac_control_asserts
	import sac_pkg::*;
(
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       arst_n,
	// register bus
	input wire logic [3:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_bit_wr,
	input wire logic [2:0] sfr_bit_sel,
	input wire logic       sfr_bit_val,
	// starts and outputs
	input wire logic       timer0_overflow,
	input wire logic       timer2_overflow,
	input wire logic       timer3_overflow,
	input wire logic       converter_power_on,
	input wire logic       converter_tracking,
	input wire logic       converter_converting,
	input wire logic       eight_bit_mode_enable,
	input wire logic       input_gain_select,
	input wire logic [7:0] result_low_byte,
	input wire logic       conversion_done_flag,
	input wire logic       window_match_flag
);
	// --------
	// shadows
	// --------
	logic [7:0] ctl;
	logic [7:0] cfg;
	logic       ctl_wr;
	logic       cfg_wr;
	logic       bit_wr;
	logic       idle;
	logic       hit;
	logic       done_clr;
	logic       win_clr;
	assign ctl_wr = sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'he8;
	assign cfg_wr = sfr_wr && sfr_page == 4'h0 && sfr_addr == 8'hbc;
	assign bit_wr = sfr_bit_wr && sfr_page == 4'h0;
	// normal track mode tracks while idle, so tracking means busy only in delayed mode
	assign idle = !converter_converting && !(converter_tracking && cfg[1]);
	assign hit = (ctl[2:0] == 3'h1 && timer0_overflow) || (ctl[2:0] == 3'h2 && timer2_overflow)
		|| (ctl[2:0] == 3'h3 && timer3_overflow);
	assign done_clr = (ctl_wr && !sfr_wdata[5]) || (bit_wr && sfr_bit_sel == 3'h5 && !sfr_bit_val);
	assign win_clr = (ctl_wr && !sfr_wdata[3]) || (bit_wr && sfr_bit_sel == 3'h3 && !sfr_bit_val);
	// status bits of the shadow are never looked at, only the written fields
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctl <= 8'h00;
			cfg <= 8'hf8;
		end else begin
			if (ctl_wr)
				ctl <= sfr_wdata;
			else if (bit_wr)
				ctl[sfr_bit_sel] <= sfr_bit_val;
			if (cfg_wr)
				cfg <= sfr_wdata;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// --------
	// properties
	// --------
	done_hold_a: assert property ($fell(conversion_done_flag) |-> $past(done_clr))
		else $error("done flag dropped without a clear");
	window_hold_a: assert property ($fell(window_match_flag) |-> $past(win_clr))
		else $error("window flag dropped without a clear");
	cfg_fields_a: assert property (cfg_wr |=> input_gain_select == cfg[0]
		&& eight_bit_mode_enable == cfg[2]) else $error("config outputs wrong");
	power_off_a: assert property ((!ctl[7] && !ctl[6]) [*2] |-> !converter_power_on && idle)
		else $error("converter active while disabled");
	sw_start_a: assert property (ctl_wr && sfr_wdata[7:6] == 2'b10 && sfr_wdata[4]
		&& sfr_wdata[2:0] == 3'h0 && idle |=> (cfg[1] ? converter_tracking : converter_converting))
		else $error("software start not taken");
	timer_start_a: assert property (ctl[7:6] == 2'b10 && hit && idle && !sfr_wr && !sfr_bit_wr
		|=> (cfg[1] ? converter_tracking : converter_converting)) else $error("timer start lost");
	timer_skip_a: assert property (ctl[7:6] == 2'b10 && ctl[2:0] != 3'h0 && !ctl[2] && !hit
		&& idle && !sfr_wr && !sfr_bit_wr |=> idle) else $error("wrong timer started");
	track_a: assert property ($rose(converter_tracking) && cfg[7:3] == 5'h00 && cfg[1] && !ctl[6]
		|-> converter_tracking [*3] ##1 converter_converting) else $error("track length wrong");
	conv_ten_a: assert property ($rose(converter_converting) && cfg[7:2] == 6'h00 && ctl[7:6]
		== 2'b10 |-> ##9 converter_converting ##1 (conversion_done_flag && !converter_converting))
		else $error("10-bit conversion length wrong");
	conv_eight_a: assert property ($rose(converter_converting) && cfg[7:2] == 6'h01
		&& ctl[7:6] == 2'b10 |-> ##7 converter_converting ##1 (conversion_done_flag
		&& result_low_byte == 8'h00)) else $error("8-bit conversion wrong");
endmodule

// ### testbench/test_sac_control.sv
// Purpose: self-checking bench of the converter control
// Assumes: oscillator at 20 MHz, unrelated in phase to sys_clk
// Notes:   read data is checked from a queue one cycle after each read
`timescale 1ns/1ps
module test_sac_control;
	import sac_pkg::*;
	// --------
	// signals
	// --------
	logic       sys_clk = 1'b0, arst_n = 1'b0, lp_osc_clk = 1'b0;
	logic [3:0] sfr_page = 4'h0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic       sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
	logic [2:0] sfr_bit_sel = 3'h0, repeat_code = 3'h0;
	logic       timer0_overflow = 1'b0, timer2_overflow = 1'b0, timer3_overflow = 1'b0;
	logic       external_convert_start_pin = 1'b0, rd_seen = 1'b0;
	logic [9:0] sample_bits = 10'h000, window_greater_than = 10'h000, window_less_than = 10'h000;
	logic       converter_power_on, converter_tracking, converter_converting;
	logic       sar_conversion_clock, eight_bit_mode_enable, input_gain_select;
	logic       conversion_done_flag, window_match_flag;
	logic [7:0] result_high_byte, result_low_byte;
	logic [31:0] seed = 32'h0000004b;
	logic [7:0] exp_q[$];
	logic [7:0] cfgs[5] = '{8'h01, 8'h04, 8'h02, 8'h09, 8'h12};
	int         fails = 0, checks = 0;

	always #4 sys_clk = !sys_clk;
	initial begin
		#3.3;
		forever #25 lp_osc_clk = !lp_osc_clk;
	end

	sac_control dut_u (.sys_clk, .arst_n, .sfr_page, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
		.sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_rdata, .timer0_overflow, .timer2_overflow,
		.timer3_overflow, .external_convert_start_pin, .lp_osc_clk, .repeat_code, .sample_bits,
		.window_greater_than, .window_less_than, .converter_power_on, .converter_tracking,
		.converter_converting, .sar_conversion_clock, .eight_bit_mode_enable, .input_gain_select,
		.result_high_byte, .result_low_byte, .conversion_done_flag, .window_match_flag);

	// --------
	// helpers
	// --------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		sfr_page <= 4'h0;
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] p, input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		sfr_page <= p;
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge sys_clk);
		sfr_rd <= 1'b0;
	endtask
	// read data stands one cycle after the read strobe
	always @(posedge sys_clk) begin
		if (rd_seen === 1'b1)
			chk(sfr_rdata, exp_q.pop_front());
		rd_seen <= sfr_rd;
	end

	// wrong timers fire first, then the right source for two cycles (one pin edge for pin sources); a second start must be ignored
	task automatic convert(input int k);
		logic [7:0] cf;
		logic [2:0] src;
		logic [9:0] r;
		logic       w;
		int         lo;
		int         cyc;
		cf = cfgs[k];
		seed = xs(seed);
		src = (k < 4) ? 3'(k) : {1'b1, seed[31:30]};
		r = cf[2] ? {seed[9:2], 2'b00} : seed[9:0];
		w = seed[19:10] < r && r < seed[29:20];
		sample_bits <= seed[9:0];
		window_greater_than <= seed[19:10];
		window_less_than <= seed[29:20];
		wr(8'hbc, cf);
		wr(8'he8, {5'h10, src});
		for (int j = 0; j < 3; j++) begin
			@(posedge sys_clk);
			sfr_wr <= j > 0 && src == 3'h0;
			sfr_wdata <= 8'h90;
			timer0_overflow <= (j > 0) == (src == 3'h1);
			timer2_overflow <= (j > 0) == (src == 3'h2);
			timer3_overflow <= (j > 0) == (src == 3'h3);
			external_convert_start_pin <= j > 0 && src[2];
		end
		@(posedge sys_clk);
		sfr_wr <= 1'b0;
		{timer0_overflow, timer2_overflow, timer3_overflow} <= 3'h0;
		external_convert_start_pin <= 1'b0;
		cyc = 1;
		while (conversion_done_flag !== 1'b1 && cyc < 400) begin
			@(posedge sys_clk);
			cyc++;
		end
		lo = (int'(cf[7:3]) + 1) * ((cf[2] ? 8 : 10) + (cf[1] ? 3 : 0));
		chk({7'h00, cyc >= lo && cyc <= lo + int'(cf[7:3]) + 6}, 8'h01);
		chk(result_high_byte, r[9:2]);
		chk(result_low_byte, {r[1:0], 6'h00});
		chk({6'h00, eight_bit_mode_enable, input_gain_select}, {6'h00, cf[2], cf[0]});
		chk({7'h00, converter_power_on}, 8'h01);
		rd(4'h0, 8'he8, {4'ha, w, src});
		@(posedge sys_clk);
		sfr_bit_wr <= 1'b1;
		sfr_bit_sel <= 3'h5;
		@(posedge sys_clk);
		sfr_bit_wr <= 1'b0;
		rd(4'h0, 8'he8, {4'h8, w, src});
		wr(8'he8, 8'h00);
		$display("test convert %0d done", k);
	endtask

	task automatic burst(input logic e);
		int cyc;
		repeat_code <= 3'h1;
		wr(8'hbc, 8'h00);
		wr(8'he8, {e, 7'h50});
		cyc = 0;
		while (conversion_done_flag !== 1'b1 && cyc < 4000) begin
			@(posedge sys_clk);
			cyc++;
		end
		chk({7'h00, cyc > 150 && cyc < 4000}, 8'h01);
		chk(result_high_byte, sample_bits[9:2]);
		repeat (8) @(posedge sys_clk);
		chk({7'h00, converter_power_on}, {7'h00, e});
		wr(8'he8, 8'h00);
		$display("test burst %0d done", e);
	endtask

	// --------
	// sequence and watchdog
	// --------
	initial begin
		repeat (3) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(4'h0, 8'he8, 8'h00);
		rd(4'h0, 8'hbc, 8'hf8);
		rd(4'h1, 8'hbc, 8'h00);
		$display("test reset done");
		for (int k = 0; k < 5; k++)
			convert(k);
		wr(8'he8, 8'h10);
		repeat (20) @(posedge sys_clk);
		chk({7'h00, converter_power_on}, 8'h00);
		rd(4'h0, 8'he8, 8'h00);
		$display("test disabled done");
		burst(1'b0);
		burst(1'b1);
		repeat (3) @(posedge sys_clk);
		test_done;
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		test_done;
	end
endmodule

bind sac_control sac_control_asserts chk_u (.sys_clk, .arst_n, .sfr_page, .sfr_addr, .sfr_wr,
	.sfr_wdata, .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .timer0_overflow, .timer2_overflow,
	.timer3_overflow, .converter_power_on, .converter_tracking, .converter_converting,
	.eight_bit_mode_enable, .input_gain_select, .result_low_byte, .conversion_done_flag,
	.window_match_flag);
